//--- rtl/rod_ilk_pkg.sv
// Shared constants and types for the rod block interlock logic.
// Assumes positions in units of 0.1 mm and group bit 0 = group 1.
package rod_ilk_pkg;
   localparam int NGRP     = 10;
   localparam int POS_W    = 16;
   localparam int GRP_W    = 4;
   localparam int GANG_MAX = 26;
   localparam int RPS_DEP  = 64;

   // Positions and limits, 0.1 mm units
   localparam logic [POS_W-1:0] POS_LOW   = 16'h23B4; // 914.0 mm
   localparam logic [POS_W-1:0] SPREAD_A  = 16'h05B4; // 146.0 mm
   localparam logic [POS_W-1:0] SPREAD_B  = 16'h05B8; // 146.4 mm
   localparam logic [POS_W-1:0] GANG_MISS = 16'h017D; // 38.1 mm

   // Group masks
   localparam logic [NGRP-1:0] GRP_NONE = 10'h000;
   localparam logic [NGRP-1:0] GRP_ONE  = 10'h001;
   localparam logic [NGRP-1:0] M_G12    = 10'h003;
   localparam logic [NGRP-1:0] M_G34    = 10'h00C;
   localparam logic [NGRP-1:0] M_G14    = 10'h00F;
   localparam logic [NGRP-1:0] M_G56    = 10'h030;
   localparam logic [NGRP-1:0] M_G16    = 10'h03F;
   localparam logic [NGRP-1:0] M_G78    = 10'h0C0;
   localparam logic [NGRP-1:0] M_G910   = 10'h300;
   localparam logic [NGRP-1:0] M_G510   = 10'h3F0;
   localparam logic [NGRP-1:0] M_SEQ_A  = 10'h3CC;
   localparam logic [NGRP-1:0] M_SEQ_B  = 10'h3C3;
   localparam logic [GRP_W-1:0] GRP_BASE = 4'h1;

   // Block condition bit indices, per channel
   localparam int C_SRM_PERIOD = 0;
   localparam int C_SRM_DOWN   = 1;
   localparam int C_SRM_UP     = 2;
   localparam int C_SRM_INOP   = 3;
   localparam int C_APM_SETDN  = 4;
   localparam int C_APM_DOWN   = 5;
   localparam int C_APM_FLOW   = 6;
   localparam int C_APM_INOP   = 7;
   localparam int C_CHG_LOW    = 8;
   localparam int C_CHG_BYP    = 9;
   localparam int C_POS_TRBL   = 10;
   localparam int C_TLM_BLK    = 11;
   localparam int C_TLM_TRBL   = 12;
   localparam int C_MCM_BLK    = 13;
   localparam int C_MCM_INOP   = 14;
   localparam int C_SEQ_TRBL   = 15;
   localparam int C_RECIRC     = 16;
   localparam int C_REFUEL     = 17;
   localparam int C_SCRAM      = 18;
   localparam int C_ALT_INS    = 19;
   localparam int C_SEL_INS    = 20;
   localparam int COND_N       = 21;

   typedef enum logic [2:0] {
      MODE_MANUAL = 3'h1, MODE_SEMI = 3'h2, MODE_AUTO = 3'h4
   } rod_mode_t;
   typedef enum logic [2:0] {
      ORD_NONE = 3'h1, ORD_A = 3'h2, ORD_B = 3'h4
   } pull_ord_t;
   typedef enum logic [2:0] {
      OUT_NONE = 3'h1, OUT_78 = 3'h2, OUT_910 = 3'h4
   } outer_t;

   // Single-bit plant and operator inputs
   typedef struct packed {
      logic ppc_auto;
      logic pr_auto;
      logic auto_sw;
      logic semi_sw;
      logic manual_sw;
      logic key_a;
      logic key_b;
      logic shutdown;
      logic startup;
      logic run;
      logic refuel;
      logic below;
      logic gang;
      logic wd;
      logic rps_wr;
      logic rps_last;
   } flags_t;
endpackage : rod_ilk_pkg

//--- rtl/seq_if.sv
// Carrier between the interlock top and the sequence checker.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface seq_if;
   import rod_ilk_pkg::*;
   logic [NGRP-1:0]            sel;
   logic [NGRP-1:0]            full_in;
   logic [NGRP-1:0]            full_out;
   logic [NGRP-1:0][POS_W-1:0] min_pos;
   logic [NGRP-1:0][POS_W-1:0] max_pos;
   logic                       wd;
   logic                       gang;
   logic                       below;
   logic                       startup;
   logic                       viol;
   modport src (output sel, full_in, full_out, min_pos, max_pos,
                output wd, gang, below, startup, input viol);
   modport chk (input sel, full_in, full_out, min_pos, max_pos,
                input wd, gang, below, startup, output viol);
endinterface : seq_if

//--- rtl/seq_check.sv
// Ganged withdrawal sequence checker for groups 1 to 10.
// Assumes synchronised inputs; the violation flag is combinational.
`timescale 1ns/1ps
module seq_check (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Selection and positions in, violation out
   seq_if.chk       sq
);
   import rod_ilk_pkg::*;

   pull_ord_t       ord_r, ord_nxt;
   outer_t          out_r, out_nxt;
   logic [NGRP-1:0] lead_r, lead_nxt;
   logic [NGRP-1:0] low, high, wide_a, wide_b;

   // Group status decode
   wire [NGRP-1:0] moved   = ~sq.full_in;
   wire [NGRP-1:0] partial = ~sq.full_in & ~sq.full_out;
   wire [NGRP-1:0] done12  = sq.full_out & M_G12;
   wire [NGRP-1:0] done34  = sq.full_out & M_G34;
   wire            p12_part = (|done12) & (done12 != M_G12);
   wire            p34_part = (|done34) & (done34 != M_G34);
   wire            sel14   = |(sq.sel & M_G14);

   // Per-group spread and height checks
   for (genvar g = 0; g < NGRP; g++) begin : g_grp
      wire [POS_W-1:0] spr = sq.max_pos[g] - sq.min_pos[g];
      assign low[g]    = sq.min_pos[g] <= POS_LOW;
      assign high[g]   = sq.min_pos[g] >= POS_LOW;
      assign wide_a[g] = low[g] & (spr >= SPREAD_A);
      assign wide_b[g] = low[g] & (spr >= SPREAD_B);
   end

   // Individual restriction checks
   wire multi = |(sq.sel & (sq.sel - GRP_ONE));
   wire r4  = sq.gang & sel14 & ~(sq.startup & sq.below);
   wire r6  = sel14 & |(moved & M_G510);
   wire r7  = sel14 & |(partial & M_G14 & ~sq.sel);
   wire r8  = (|(sq.sel & M_G12) & p34_part)
            | (|(sq.sel & M_G34) & p12_part);
   wire r10 = sq.gang & |(sq.sel & ~M_G16);
   wire [NGRP-1:0] spr_bad = (ord_r == ORD_A) ? (wide_a & M_SEQ_A)
                           : (ord_r == ORD_B) ? (wide_b & M_SEQ_B)
                           : GRP_NONE;
   wire r11 = |(sq.sel & spr_bad);
   wire [NGRP-1:0] need = M_G56 | lead_r;
   wire clr13 = (high & need) == need;
   wire r13 = ~clr13 & (((out_r == OUT_78) & |(sq.sel & M_G910))
            | ((out_r == OUT_910) & |(sq.sel & M_G78)));

   // Below the setpoint every restriction applies except r4 in startup; two groups never
   assign sq.viol = multi | (sq.wd & r4)
                  | (sq.wd & sq.below & (r6 | r7 | r8 | r10 | r11 | r13));

   // Which pull order family is in use, from the first pair moved
   always_comb begin
      ord_nxt = ord_r;
      unique case (ord_r)
         ORD_NONE: begin
            if (|(moved & M_G12)) ord_nxt = ORD_A;
            else if (|(moved & M_G34)) ord_nxt = ORD_B;
         end
         ORD_A, ORD_B: begin
            if (!(|(moved & M_G14))) ord_nxt = ORD_NONE;
         end
      endcase
   end

   // Which outer pair moved first, and the group that led
   always_comb begin
      out_nxt  = out_r;
      lead_nxt = lead_r;
      unique case (out_r)
         OUT_NONE: begin
            if (|(moved & M_G78)) begin
               out_nxt  = OUT_78;
               lead_nxt = moved & M_G78;
            end else if (|(moved & M_G910)) begin
               out_nxt  = OUT_910;
               lead_nxt = moved & M_G910;
            end
         end
         OUT_78, OUT_910: begin
            if (!(|(moved & (M_G78 | M_G910)))) begin
               out_nxt  = OUT_NONE;
               lead_nxt = GRP_NONE;
            end
         end
      endcase
   end

   // State registers
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ord_r  <= ORD_NONE;
         out_r  <= OUT_NONE;
         lead_r <= GRP_NONE;
      end else begin
         ord_r  <= ord_nxt;
         out_r  <= out_nxt;
         lead_r <= lead_nxt;
      end
   end
endmodule : seq_check

//--- rtl/rod_block_interlock_logic.sv
// Rod block interlock: mode control, reference sequence, block outputs.
// Assumes all inputs are asynchronous to i_clk and held stable briefly.
`timescale 1ns/1ps
module rod_block_interlock_logic #(
   parameter int NROD = rod_ilk_pkg::GANG_MAX,
   parameter int RDEP = rod_ilk_pkg::RPS_DEP
) (
   // Clock and reset
   input  wire logic                        i_clk,
   input  wire logic                        i_sys_rst,
   // Operator and plant mode inputs
   input  wire logic                        i_ppc_auto,
   input  wire logic                        i_pr_auto,
   input  wire logic                        i_auto_sw,
   input  wire logic                        i_semi_sw,
   input  wire logic                        i_manual_sw,
   input  wire logic                        i_key_a,
   input  wire logic                        i_key_b,
   // Reactor mode and power
   input  wire logic                        i_mode_shutdown,
   input  wire logic                        i_mode_startup,
   input  wire logic                        i_mode_run,
   input  wire logic                        i_mode_refuel,
   input  wire logic                        i_below_low_power_setpoint,
   // Block conditions, channel A [0] and B [1]
   input  wire logic [1:0][rod_ilk_pkg::COND_N-1:0] i_cond,
   // Selection, with the active gang set already applied
   input  wire logic [rod_ilk_pkg::NGRP-1:0] i_sel_grp,
   input  wire logic [NROD-1:0]             i_sel_rods,
   input  wire logic                        i_gang_mode,
   input  wire logic                        i_withdraw_req,
   // Rod position data
   input  wire logic [rod_ilk_pkg::NGRP-1:0] i_grp_full_in,
   input  wire logic [rod_ilk_pkg::NGRP-1:0] i_grp_full_out,
   input  wire logic [rod_ilk_pkg::NGRP-1:0][rod_ilk_pkg::POS_W-1:0] i_grp_min_pos,
   input  wire logic [rod_ilk_pkg::NGRP-1:0][rod_ilk_pkg::POS_W-1:0] i_grp_max_pos,
   input  wire logic [rod_ilk_pkg::POS_W-1:0] i_gang_min_pos,
   input  wire logic [rod_ilk_pkg::POS_W-1:0] i_gang_max_pos,
   input  wire logic [NROD-1:0]             i_rod_sep,
   // Reference pull sequence load
   input  wire logic                        i_rps_wr,
   input  wire logic [rod_ilk_pkg::GRP_W-1:0] i_rps_grp,
   input  wire logic                        i_rps_last,
   // Block and status outputs
   output logic [NROD-1:0]                  o_rod_block,
   output logic                             o_all_block,
   output logic                             o_seq_block,
   output logic                             o_rps_alarm,
   output logic                             o_rps_load_done,
   output logic                             o_auto_active,
   output rod_ilk_pkg::rod_mode_t           o_mode
);
   import rod_ilk_pkg::*;
   localparam int RAW = $clog2(RDEP);

   // Synchroniser stages
   flags_t                     s1_f, s2_f;
   logic [1:0][COND_N-1:0]     s1_c, s2_c;
   logic [NGRP-1:0]            s1_sel, s2_sel, s1_fi, s2_fi, s1_fo, s2_fo;
   logic [NGRP-1:0][POS_W-1:0] s1_mn, s2_mn, s1_mx, s2_mx;
   logic [POS_W-1:0]           s1_gmn, s2_gmn, s1_gmx, s2_gmx;
   logic [NROD-1:0]            s1_rods, s2_rods, s1_sep, s2_sep;
   logic [GRP_W-1:0]           s1_rg, s2_rg;
   wire flags_t f_raw = {i_ppc_auto, i_pr_auto, i_auto_sw, i_semi_sw,
      i_manual_sw, i_key_a, i_key_b, i_mode_shutdown, i_mode_startup,
      i_mode_run, i_mode_refuel, i_below_low_power_setpoint, i_gang_mode,
      i_withdraw_req, i_rps_wr, i_rps_last};

   // State
   rod_mode_t        mode_r, mode_nxt;
   logic             auto_d_r, wr_d_r, exp_fo_d_r;
   logic             done_r;
   logic [RAW-1:0]   wptr_r, ptr_r, last_r;
   logic [GRP_W-1:0] rps_mem [RDEP];

   seq_if sq ();

   // Two-flop synchronisers on every outside input
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         {s1_f, s2_f, s1_c, s2_c, s1_sel, s2_sel} <= '0;
         {s1_fi, s2_fi, s1_fo, s2_fo, s1_mn, s2_mn} <= '0;
         {s1_mx, s2_mx, s1_gmn, s2_gmn, s1_gmx, s2_gmx} <= '0;
         {s1_rods, s2_rods, s1_sep, s2_sep, s1_rg, s2_rg} <= '0;
      end else begin
         {s1_f, s1_c, s1_sel, s1_fi, s1_fo} <= {f_raw, i_cond, i_sel_grp,
                                               i_grp_full_in, i_grp_full_out};
         {s1_mn, s1_mx, s1_gmn, s1_gmx} <= {i_grp_min_pos, i_grp_max_pos,
                                           i_gang_min_pos, i_gang_max_pos};
         {s1_rods, s1_sep, s1_rg} <= {i_sel_rods, i_rod_sep, i_rps_grp};
         {s2_f, s2_c, s2_sel, s2_fi, s2_fo} <= {s1_f, s1_c, s1_sel, s1_fi, s1_fo};
         {s2_mn, s2_mx, s2_gmn, s2_gmx} <= {s1_mn, s1_mx, s1_gmn, s1_gmx};
         {s2_rods, s2_sep, s2_rg} <= {s1_rods, s1_sep, s1_rg};
      end
   end

   // Sequence checker hookup; selection already mapped by gang set
   assign sq.sel      = s2_sel;
   assign sq.full_in  = s2_fi;
   assign sq.full_out = s2_fo;
   assign sq.min_pos  = s2_mn;
   assign sq.max_pos  = s2_mx;
   assign sq.wd       = s2_f.wd;
   assign sq.gang     = s2_f.gang;
   assign sq.below    = s2_f.below;
   assign sq.startup  = s2_f.startup;

   seq_check u_seq (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .sq        (sq.chk)
   );

   // Either channel raises a condition
   wire [COND_N-1:0] c = s2_c[0] | s2_c[1];
   wire run   = s2_f.run;
   wire below = s2_f.below;

   // Gang misalignment across members of the selected gang
   wire [POS_W-1:0] gspr = s2_gmx - s2_gmn;
   wire misalign = (s2_gmx > s2_gmn) & (gspr > GANG_MISS);

   // All-rod block sources, held while the source stands
   wire blk_nrun = ~run & (c[C_SRM_PERIOD] | c[C_SRM_DOWN] | c[C_SRM_UP]
                 | c[C_SRM_INOP] | c[C_APM_SETDN]);
   wire blk_run  = run & (c[C_APM_DOWN] | c[C_APM_FLOW]
                 | c[C_APM_INOP]);
   wire blk_ref  = s2_f.refuel & c[C_REFUEL];
   wire blk_hi   = ~below & (c[C_TLM_BLK] | c[C_TLM_TRBL]
                 | c[C_MCM_BLK] | c[C_MCM_INOP]);
   wire blk_lo   = below & c[C_SEQ_TRBL];
   wire blk_misc = s2_f.shutdown | c[C_CHG_LOW] | c[C_CHG_BYP]
                 | c[C_POS_TRBL] | c[C_SCRAM] | c[C_ALT_INS]
                 | c[C_SEL_INS] | c[C_RECIRC];
   wire all_nxt  = blk_nrun | blk_run | blk_ref | blk_hi | blk_lo
                 | blk_misc | misalign;

   // Reference pull sequence compare
   wire [GRP_W-1:0] exp_grp = rps_mem[ptr_r];
   wire [NGRP-1:0]  exp_sel = GRP_ONE << (exp_grp - GRP_BASE);
   wire exp_fo  = |(exp_sel & s2_fo);
   wire ref_on  = (mode_r == MODE_AUTO) | (mode_r == MODE_SEMI);
   wire rps_viol = ref_on & s2_f.wd & (|s2_sel)
                 & (~done_r | (s2_sel != exp_sel));
   wire seq_viol = sq.viol;

   // Per-rod block: all, own separation, or the selected gang
   wire [NROD-1:0] rod_nxt = {NROD{all_nxt}} | s2_sep
                   | (s2_rods & {NROD{seq_viol | rps_viol}});
   wire any_blk = all_nxt | (|s2_sep) | seq_viol | rps_viol;

   // Mode control
   wire auto_rise = s2_f.auto_sw & ~auto_d_r;
   // Plant side in auto and rod mode switch off manual
   wire auto_ok   = s2_f.ppc_auto & s2_f.pr_auto & ~s2_f.manual_sw;
   wire load_ok   = (mode_r == MODE_MANUAL) & s2_f.key_a & s2_f.key_b;
   wire wr_rise   = s2_f.rps_wr & ~wr_d_r;

   always_comb begin
      mode_nxt = mode_r;
      unique case (mode_r)
         MODE_MANUAL: begin
            if (auto_rise & auto_ok & ~any_blk) mode_nxt = MODE_AUTO;
            else if (s2_f.semi_sw & ~any_blk) mode_nxt = MODE_SEMI;
         end
         MODE_SEMI: begin
            if (s2_f.manual_sw | any_blk) mode_nxt = MODE_MANUAL;
            else if (auto_rise & auto_ok) mode_nxt = MODE_AUTO;
         end
         MODE_AUTO: begin
            if (~auto_ok | s2_f.manual_sw) mode_nxt = MODE_MANUAL;
            else if (any_blk) mode_nxt = MODE_MANUAL;
         end
      endcase
   end

   // Mode, edge detect and outputs; reset blocks everything
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode_r        <= MODE_MANUAL;
         o_mode        <= MODE_MANUAL;
         o_auto_active <= 1'b0;
         o_rod_block   <= '1;
         o_all_block   <= 1'b1;
         o_seq_block   <= 1'b1;
         o_rps_alarm   <= 1'b0;
         auto_d_r      <= 1'b0;
         wr_d_r        <= 1'b0;
         exp_fo_d_r    <= 1'b0;
      end else begin
         mode_r        <= mode_nxt;
         o_mode        <= mode_nxt;
         o_auto_active <= mode_nxt == MODE_AUTO;
         o_rod_block   <= rod_nxt;
         o_all_block   <= all_nxt;
         o_seq_block   <= seq_viol;
         o_rps_alarm   <= rps_viol;
         auto_d_r      <= s2_f.auto_sw;
         wr_d_r        <= s2_f.rps_wr;
         exp_fo_d_r    <= exp_fo;
      end
   end

   // Reference load pointers; any loss of permission aborts the load
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         done_r <= 1'b0;
         wptr_r <= '0;
         ptr_r  <= '0;
         last_r <= '0;
      end else if (!load_ok) begin
         wptr_r <= '0;
         if (exp_fo & ~exp_fo_d_r & (ptr_r != last_r))
            ptr_r <= ptr_r + 1'b1;
      end else if (wr_rise) begin
         done_r <= s2_f.rps_last;
         if (s2_f.rps_last) begin
            last_r <= wptr_r;
            wptr_r <= '0;
            ptr_r  <= '0;
         end else begin
            wptr_r <= wptr_r + 1'b1;
         end
      end
   end

   // Reference storage, written only while loading is permitted
   always_ff @(posedge i_clk) begin
      if (load_ok & wr_rise) rps_mem[wptr_r] <= s2_rg;
   end

   assign o_rps_load_done = done_r;
endmodule : rod_block_interlock_logic

//--- tb/plant_model.sv
// Plant position model: per-group state turned into position data.
// Assumes each group is fully in, partly out or fully out.
`timescale 1ns/1ps
module plant_model (
   // Group state from the bench
   input  wire logic [rod_ilk_pkg::NGRP-1:0]                        i_out,
   input  wire logic [rod_ilk_pkg::NGRP-1:0]                        i_part,
   // Position data towards the interlock
   output logic [rod_ilk_pkg::NGRP-1:0]                             o_full_in,
   output logic [rod_ilk_pkg::NGRP-1:0]                             o_full_out,
   output logic [rod_ilk_pkg::NGRP-1:0][rod_ilk_pkg::POS_W-1:0]     o_min,
   output logic [rod_ilk_pkg::NGRP-1:0][rod_ilk_pkg::POS_W-1:0]     o_max
);
   import rod_ilk_pkg::*;
   // Full-out travel, value arbitrary but above the low band
   localparam logic [POS_W-1:0] FULL_POS = 16'h9000;
   // Fully in reads zero; a part group keeps a small spread
   assign o_full_in  = ~(i_out | i_part);
   assign o_full_out = i_out;
   for (genvar g = 0; g < NGRP; g++) begin : g_pos
      assign o_min[g] = i_out[g] ? FULL_POS : (i_part[g] ? 16'h0100 : 16'h0000);
      assign o_max[g] = i_out[g] ? FULL_POS : (i_part[g] ? 16'h0180 : 16'h0000);
   end
endmodule : plant_model

//--- tb/rod_ilk_props.sv
// Port-level assertions for the rod block interlock.
// Assumes one clock; four held samples cover sync plus output flop.
`timescale 1ns/1ps
module rod_ilk_props #(
   parameter int NROD = rod_ilk_pkg::GANG_MAX,
   parameter int RDEP = rod_ilk_pkg::RPS_DEP
) (
   // Clock, reset and watched ports
   input wire logic                                     i_clk,
   input wire logic                                     i_sys_rst,
   input wire logic                                     i_ppc_auto,
   input wire logic                                     i_manual_sw,
   input wire logic                                     i_key_a,
   input wire logic                                     i_mode_shutdown,
   input wire logic                                     i_mode_run,
   input wire logic                                     i_below_low_power_setpoint,
   input wire logic [1:0][rod_ilk_pkg::COND_N-1:0]      i_cond,
   input wire logic [rod_ilk_pkg::NGRP-1:0]             i_sel_grp,
   input wire logic                                     i_withdraw_req,
   input wire logic [NROD-1:0]                          i_rod_sep,
   input wire logic [NROD-1:0]                          o_rod_block,
   input wire logic                                     o_all_block,
   input wire logic                                     o_seq_block,
   input wire logic                                     o_rps_load_done,
   input wire logic                                     o_auto_active,
   input wire rod_ilk_pkg::rod_mode_t                   o_mode
);
   import rod_ilk_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // Held causes reach the registered outputs
   property p_shut; i_mode_shutdown [*4] |-> o_all_block; endproperty
   property p_scram; i_cond[1][C_SCRAM] [*4] |-> o_all_block; endproperty
   property p_srm;
      ((i_cond[0][C_SRM_INOP] || i_cond[1][C_SRM_INOP]) && !i_mode_run) [*4] |-> o_all_block;
   endproperty
   property p_apm;
      ((i_cond[0][C_APM_FLOW] || i_cond[1][C_APM_FLOW]) && i_mode_run) [*4] |-> o_all_block;
   endproperty
   property p_tlm;
      ((i_cond[0][C_TLM_BLK] || i_cond[1][C_TLM_BLK]) && !i_below_low_power_setpoint) [*4]
         |-> o_all_block;
   endproperty
   property p_sep; i_rod_sep[0] [*4] |-> o_rod_block[0]; endproperty
   property p_multi;
      ($countones(i_sel_grp) > 1 && i_withdraw_req) [*4] |-> o_seq_block;
   endproperty
   // Mode rules
   property p_drop; o_all_block |-> ##[0:1] !o_auto_active; endproperty
   property p_ppc; (!i_ppc_auto) [*4] |-> !o_auto_active; endproperty
   property p_man; i_manual_sw [*4] |-> !o_auto_active; endproperty
   property p_auto; o_auto_active |-> o_mode == MODE_AUTO; endproperty
   property p_key; (!i_key_a) [*6] |-> !$rose(o_rps_load_done); endproperty
   a_shut: assert property (p_shut) else $error("shutdown not blocking");
   a_scram: assert property (p_scram) else $error("scram not blocking");
   a_srm: assert property (p_srm) else $error("source range not blocking");
   a_apm: assert property (p_apm) else $error("power monitor not blocking");
   a_tlm: assert property (p_tlm) else $error("thermal monitor not blocking");
   a_sep: assert property (p_sep) else $error("separated rod not blocked");
   a_multi: assert property (p_multi) else $error("two groups not blocked");
   a_drop: assert property (p_drop) else $error("auto kept under block");
   a_ppc: assert property (p_ppc) else $error("auto without controller");
   a_man: assert property (p_man) else $error("auto kept at manual");
   a_auto: assert property (p_auto) else $error("auto flag and mode differ");
   a_key: assert property (p_key) else $error("load done without key");
   // Main scenarios reached
   c_auto: cover property (o_auto_active);
   c_load: cover property ($rose(o_rps_load_done));
   c_seq: cover property (o_seq_block);
endmodule : rod_ilk_props
bind rod_block_interlock_logic rod_ilk_props #(.NROD(NROD), .RDEP(RDEP)) props (.*);

//--- tb/rod_block_interlock_logic_tb_top.sv
// Self-checking bench for the rod block interlock.
// Assumes inputs change on falling edges; outputs settle 3 edges later.
`timescale 1ns/1ps
module rod_block_interlock_logic_tb_top;
   import rod_ilk_pkg::*;
   localparam int NROD = GANG_MAX;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_ppc_auto, i_pr_auto, i_auto_sw, i_semi_sw, i_manual_sw, i_key_a, i_key_b;
   logic i_mode_shutdown, i_mode_startup, i_mode_run, i_mode_refuel;
   logic i_below_low_power_setpoint, i_gang_mode, i_withdraw_req, i_rps_wr, i_rps_last;
   logic [1:0][COND_N-1:0]     i_cond;
   logic [NGRP-1:0]            i_sel_grp, i_grp_full_in, i_grp_full_out, grp_out, grp_part;
   logic [NROD-1:0]            i_sel_rods, i_rod_sep, o_rod_block;
   logic [NGRP-1:0][POS_W-1:0] i_grp_min_pos, i_grp_max_pos;
   logic [POS_W-1:0]           i_gang_min_pos, i_gang_max_pos;
   logic [GRP_W-1:0]           i_rps_grp;
   logic o_all_block, o_seq_block, o_rps_alarm, o_rps_load_done, o_auto_active;
   rod_mode_t o_mode;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int always_blk[7] = '{C_CHG_LOW, C_CHG_BYP, C_POS_TRBL, C_RECIRC, C_SCRAM, C_ALT_INS, C_SEL_INS};

   rod_block_interlock_logic #(.NROD(NROD), .RDEP(RPS_DEP)) dut (.*);
   plant_model plant (.i_out(grp_out), .i_part(grp_part), .o_full_in(i_grp_full_in),
      .o_full_out(i_grp_full_out), .o_min(i_grp_min_pos), .o_max(i_grp_max_pos));

   // 250 MHz clock and hang guard
   always #2 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic w(input int n);
      repeat (n) @(negedge i_clk);
   endtask : w
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish();
      if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   // One condition in mode m (0 startup, 1 run, 2 refuel), then cleared
   task automatic cb(input int c, input logic [1:0] m, input logic b, input logic e);
      i_mode_startup = (m == 2'h0);
      i_mode_run = (m == 2'h1);
      i_mode_refuel = (m == 2'h2);
      i_below_low_power_setpoint = b;
      i_cond[c % 2][c] = 1'b1;
      w(4); chk(o_all_block, e);
      i_cond = '0;
      w(4); chk(o_all_block, 1'b0);
   endtask : cb
   task automatic press();
      i_auto_sw = 1'b1;
      w(4); i_auto_sw = 1'b0;
      w(4);
   endtask : press
   task automatic ld(input logic [GRP_W-1:0] g, input logic last);
      i_rps_grp = g;
      i_rps_last = last;
      i_rps_wr = 1'b1;
      w(3); i_rps_wr = 1'b0;
      w(5);
   endtask : ld
   task automatic sq(input logic [NGRP-1:0] o, p, s, input logic e);
      grp_out = o;
      grp_part = p;
      i_sel_grp = s;
      w(4); chk(o_seq_block, e);
   endtask : sq

   initial begin
      {i_ppc_auto, i_pr_auto, i_auto_sw, i_semi_sw, i_manual_sw, i_key_a, i_key_b} = '0;
      {i_mode_shutdown, i_mode_run, i_mode_refuel, i_gang_mode, i_withdraw_req} = '0;
      {i_rps_wr, i_rps_last, i_mode_startup, i_below_low_power_setpoint} = 4'h3;
      {i_cond, i_sel_grp, grp_out, grp_part, i_rod_sep, i_rps_grp} = '0;
      {i_gang_min_pos, i_gang_max_pos} = '0;
      i_sel_rods = '1;
      w(8); chk(o_all_block, 1'b1); chk(o_mode, MODE_MANUAL);
      i_sys_rst = 1'b0;
      w(4); chk(o_all_block, 1'b0);
      cb(C_SRM_PERIOD, 2'h0, 1'b1, 1'b1);
      cb(C_SRM_PERIOD, 2'h1, 1'b0, 1'b0);
      cb(C_SRM_DOWN, 2'h2, 1'b1, 1'b1);
      cb(C_SRM_UP, 2'h0, 1'b1, 1'b1);
      cb(C_SRM_INOP, 2'h0, 1'b1, 1'b1);
      cb(C_APM_SETDN, 2'h0, 1'b1, 1'b1);
      cb(C_APM_DOWN, 2'h1, 1'b0, 1'b1);
      cb(C_APM_DOWN, 2'h0, 1'b1, 1'b0);
      cb(C_APM_FLOW, 2'h1, 1'b0, 1'b1);
      cb(C_APM_INOP, 2'h1, 1'b0, 1'b1);
      cb(C_REFUEL, 2'h2, 1'b1, 1'b1);
      cb(C_REFUEL, 2'h0, 1'b1, 1'b0);
      cb(C_TLM_BLK, 2'h1, 1'b0, 1'b1);
      cb(C_TLM_BLK, 2'h0, 1'b1, 1'b0);
      cb(C_TLM_TRBL, 2'h1, 1'b0, 1'b1);
      cb(C_MCM_BLK, 2'h1, 1'b0, 1'b1);
      cb(C_MCM_INOP, 2'h1, 1'b0, 1'b1);
      cb(C_SEQ_TRBL, 2'h0, 1'b1, 1'b1);
      foreach (always_blk[k]) cb(always_blk[k], 2'(k % 3), 1'b1, 1'b1);
      i_mode_shutdown = 1'b1;
      w(4); chk(o_all_block, 1'b1);
      i_mode_shutdown = 1'b0;
      i_rod_sep = 26'h0000001;
      w(4); chk(o_rod_block, 32'h00000001);
      i_rod_sep = '0;
      i_gang_mode = 1'b1;
      i_gang_max_pos = GANG_MISS;
      w(4); chk(o_all_block, 1'b0);
      i_gang_max_pos = GANG_MISS + 16'h0001;
      w(4); chk(o_all_block, 1'b1);
      i_gang_max_pos = '0;
      {i_ppc_auto, i_pr_auto} = 2'h3;
      w(4); press(); chk(o_mode, MODE_AUTO); chk(o_auto_active, 1'b1);
      i_cond[1][C_SCRAM] = 1'b1;
      w(4); chk(o_mode, MODE_MANUAL);
      i_cond = '0;
      w(4); chk(o_mode, MODE_MANUAL);
      press(); chk(o_mode, MODE_AUTO);
      i_manual_sw = 1'b1;
      w(4); chk(o_auto_active, 1'b0);
      i_manual_sw = 1'b0;
      press(); i_ppc_auto = 1'b0;
      w(4); chk(o_mode, MODE_MANUAL);
      press(); chk(o_mode, MODE_MANUAL);
      i_key_a = 1'b1;
      ld(4'h1, 1'b1); chk(o_rps_load_done, 1'b0);
      i_key_b = 1'b1;
      ld(4'h1, 1'b0); chk(o_rps_load_done, 1'b0);
      ld(4'h2, 1'b1); chk(o_rps_load_done, 1'b1);
      i_withdraw_req = 1'b1;
      sq(10'h000, 10'h000, 10'h003, 1'b1);
      sq(10'h000, 10'h000, 10'h001, 1'b0);
      sq(10'h000, 10'h000, 10'h040, 1'b1);
      sq(10'h000, 10'h010, 10'h001, 1'b1);
      sq(10'h000, 10'h001, 10'h002, 1'b1);
      sq(10'h002, 10'h000, 10'h004, 1'b1);
      sq(10'h002, 10'h000, 10'h001, 1'b0);
      i_gang_mode = 1'b0;
      sq(10'h000, 10'h040, 10'h100, 1'b1);
      i_semi_sw = 1'b1;
      sq(10'h002, 10'h000, 10'h001, 1'b0);
      chk(o_mode, MODE_SEMI);
      chk(o_rps_alarm, 1'b0);
      i_sel_grp = 10'h002;
      w(3);
      chk(o_rps_alarm, 1'b1);
      tally_and_finish();
   end
endmodule : rod_block_interlock_logic_tb_top
